// *** dds_decoder.sv ***
// operand decoder for divide and decimal subtract with borrow forms
// assumes: request presented one cycle, result registered next cycle
//
// Overview of operation
// - size bit zero byte, one word
// - five-bit field, 00000 and 01100 address modes
// - long forms refuse 10000/10001, allow 10010/10011 pairs
// - prefix 00001001 makes divide source indirect
// - indirect source adds one byte, three cycles
// - sized divide 18 register, 20 memory
// - long divide 40/42 cycles, three bytes
// - long forms refuse indirection prefix
// - signed word divide adds six bytes
// - unsigned immediate 3/18, word adds 1/5
// - unsigned general word adds five cycles
// - extended immediate 18, word adds 1/6
// - extended general word adds six cycles
// - decimal immediate 4/2 register, 4/4 memory
// - decimal immediate word size adds one byte
// - destination prefix 00001001, both 01001001
`timescale 1ns/100ps

module dds_decoder
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dds_pkg::dds_req_t req_i,
  output dds_pkg::dds_rsp_t rsp_o
);
  import dds_pkg::*;

  // ==========================================================
  // operand classification
  wire logic src_is_reg;
  wire logic dst_is_reg;
  wire logic src_is_mem;
  wire logic dst_is_mem;
  wire logic src_disp;
  wire logic dst_disp;
  wire logic [3:0] src_ext;
  wire logic [3:0] dst_ext;

  // register-like codes: 1xxxx registers, 0001x address registers
  assign src_is_reg = req_i.src[4] | (req_i.src[4:1] == 4'h1);
  assign dst_is_reg = req_i.dst[4] | (req_i.dst[4:1] == 4'h1);
  assign src_is_mem = ~src_is_reg;
  assign dst_is_mem = ~dst_is_reg;
  assign src_disp = 1'b1;
  assign dst_disp = 1'b1;

  function automatic logic [3:0] disp_len(input logic [4:0] code);
    logic [3:0] n;
    n = 4'h0;
    if (code == DDS_OP_D8_A0 || code == DDS_OP_D8_A1 || code == DDS_OP_D8_SB || code == DDS_OP_D8_FB)
      n = 4'h1;
    else if (code == DDS_OP_D16_A0 || code == DDS_OP_D16_A1 || code == DDS_OP_D16_SB || code == DDS_OP_D16_FB)
      n = 4'h2;
    else if (code == DDS_OP_ABS16)
      n = 4'h2;
    else if (code == DDS_OP_D24_A0 || code == DDS_OP_D24_A1 || code == DDS_OP_ABS24)
      n = 4'h3;
    return n;
  endfunction

  assign src_ext = disp_len(req_i.src);
  assign dst_ext = disp_len(req_i.dst);

  // ==========================================================
  // form groups
  wire logic is_long;
  wire logic is_sized;
  wire logic is_imm_div;
  wire logic is_dsb;
  wire logic is_word;

  assign is_long = (req_i.form == DDS_F_SDIV_L) | (req_i.form == DDS_F_UDIV_L) | (req_i.form == DDS_F_XDIV_L);
  assign is_sized = (req_i.form == DDS_F_SDIV) | (req_i.form == DDS_F_UDIV) | (req_i.form == DDS_F_XDIV);
  assign is_imm_div = (req_i.form == DDS_F_UDIV_IMM) | (req_i.form == DDS_F_XDIV_IMM);
  assign is_dsb = (req_i.form == DDS_F_DSB_IMM);
  // size bit selects byte or word
  assign is_word = (req_i.size == DDS_SIZE_WORD) & ~is_long;

  // ==========================================================
  // prefix decode
  wire logic pfx_first;
  wire logic pfx_both;
  wire logic pfx_bad;
  wire logic src_ind;
  wire logic dst_ind;

  assign pfx_first = req_i.pfx_valid & (req_i.pfx == DDS_PFX_FIRST);
  assign pfx_both = req_i.pfx_valid & (req_i.pfx == DDS_PFX_BOTH);
  // same prefix marks decimal destination, second value both
  assign src_ind = (is_sized & pfx_first) | (is_dsb & req_i.dsb_gen & pfx_both);
  assign dst_ind = is_dsb & (pfx_first | pfx_both);
  // long forms take no prefix; unknown prefixes also refused
  assign pfx_bad = req_i.pfx_valid & (is_long | is_imm_div | ~(pfx_first | pfx_both)
                   | (is_sized & pfx_both) | (is_dsb & ~req_i.dsb_gen & pfx_both));

  // long forms reject the two upper register halves
  wire logic long_bad;
  assign long_bad = is_long & ((req_i.src == DDS_OP_REG2) | (req_i.src == DDS_OP_REG3));

  // ==========================================================
  // byte count
  logic [3:0] bytes_d;
  logic [5:0] cycles_d;

  always_comb
  begin
    bytes_d = 4'h0;
    if (is_long)
    begin
      bytes_d = DDS_LEN_LONG + src_ext;
    end
    else if (is_sized)
    begin
      bytes_d = DDS_LEN_SIZED + src_ext;
      if (src_ind)
        bytes_d = bytes_d + DDS_LEN_IND_ADD;
      // signed word form counted six more bytes
      if (is_word && req_i.form == DDS_F_SDIV)
        bytes_d = bytes_d + DDS_LEN_SDIV_WORD_ADD;
    end
    else if (is_imm_div)
    begin
      // immediate divide grows with word size
      bytes_d = DDS_LEN_IMM + (is_word ? DDS_LEN_WORD_ADD : 4'h0);
    end
    else if (is_dsb)
    begin
      bytes_d = (req_i.dsb_gen ? DDS_LEN_DSB_GEN + src_ext : DDS_LEN_DSB_IMM) + dst_ext;
      if (src_ind || dst_ind)
        bytes_d = bytes_d + DDS_LEN_IND_ADD;
      // word adds one immediate byte, immediate form only
      if (is_word && !req_i.dsb_gen)
        bytes_d = bytes_d + DDS_LEN_WORD_ADD;
    end
  end

  // ==========================================================
  // cycle count
  always_comb
  begin
    cycles_d = 6'h00;
    if (is_long)
    begin
      cycles_d = src_is_mem ? DDS_CYC_LONG_MEM : DDS_CYC_LONG_REG;
    end
    else if (is_sized)
    begin
      cycles_d = src_is_mem ? DDS_CYC_DIV_MEM : DDS_CYC_DIV_REG;
      if (src_ind)
        cycles_d = cycles_d + DDS_CYC_IND_ADD;
      if (is_word && req_i.form == DDS_F_UDIV)
        cycles_d = cycles_d + DDS_CYC_UNSIGNED_DIVIDE_WORD;
      if (is_word && req_i.form == DDS_F_XDIV)
        cycles_d = cycles_d + DDS_CYC_EXTENDED_SIGNED_DIVIDE_WORD;
    end
    else if (req_i.form == DDS_F_UDIV_IMM)
    begin
      cycles_d = DDS_CYC_DIV_REG + (is_word ? DDS_CYC_UNSIGNED_DIVIDE_WORD : 6'h00);
    end
    else if (req_i.form == DDS_F_XDIV_IMM)
    begin
      cycles_d = DDS_CYC_DIV_REG + (is_word ? DDS_CYC_EXTENDED_SIGNED_DIVIDE_WORD : 6'h00);
    end
    else if (is_dsb)
    begin
      if (!req_i.dsb_gen)
      begin
        cycles_d = dst_is_mem ? DDS_CYC_DSB_ONE : DDS_CYC_DSB_RR;
      end
      else
      begin
        // memory on each side raises count
        if (src_is_mem && dst_is_mem)
          cycles_d = DDS_CYC_DSB_TWO;
        else if (src_is_mem || dst_is_mem)
          cycles_d = DDS_CYC_DSB_ONE;
        else
          cycles_d = DDS_CYC_DSB_RR;
      end
      if (src_ind)
        cycles_d = cycles_d + DDS_CYC_IND_ADD;
      if (dst_ind)
        cycles_d = cycles_d + DDS_CYC_IND_ADD;
    end
  end

  // ==========================================================
  // result register
  dds_rsp_t rsp_d;
  dds_rsp_t rsp_q;

  assign rsp_d.valid = req_i.valid;
  assign rsp_d.illegal = req_i.valid & (pfx_bad | long_bad);
  assign rsp_d.word = is_word;
  assign rsp_d.src_ind = src_ind;
  assign rsp_d.dst_ind = dst_ind;
  assign rsp_d.src_mem = src_is_mem & ~is_imm_div & ~(is_dsb & ~req_i.dsb_gen);
  assign rsp_d.dst_mem = is_dsb & dst_is_mem;
  // high pair flagged for long forms
  assign rsp_d.long_pair_hi = is_long & (req_i.src == DDS_OP_HIGH_PAIR);
  assign rsp_d.bytes = bytes_d;
  assign rsp_d.cycles = cycles_d;

  // outputs from flip-flops; cleared on reset so no stale decode leaks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rsp_q <= '0;
    else
      rsp_q <= rsp_d;
  end

  assign rsp_o = rsp_q;

endmodule

// *** dds_decoder_properties.sv ***
// port checks for the divide / decimal-subtract decoder
// assumes: bound to dds_decoder, one clock, sync reset
`timescale 1ns/100ps
module dds_props
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dds_pkg::dds_req_t req_i,
  input wire dds_pkg::dds_rsp_t rsp_o
);
  import dds_pkg::*;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // request qualifiers
  wire logic np = req_i.valid & ~req_i.pfx_valid;
  wire logic lng = req_i.form inside {DDS_F_SDIV_L, DDS_F_UDIV_L, DDS_F_XDIV_L};
  wire logic sm = ~req_i.src[4] & (req_i.src[4:1] != 4'h1);
  a_size_bit: assert property (req_i.valid & ~lng |=> rsp_o.word == $past(req_i.size))
    else $error("word flag wrong");
  a_long_bad_pair: assert property (req_i.valid & lng & (req_i.src[4:1] == 4'h8) |=> rsp_o.illegal)
    else $error("long form took bad code");
  a_long_pfx_bad: assert property (req_i.valid & lng & req_i.pfx_valid |=> rsp_o.illegal)
    else $error("long form took prefix");
  a_long_cycles: assert property (np & lng |=> rsp_o.cycles == ($past(sm) ? 6'h2a : 6'h28))
    else $error("long cycles wrong");
  a_udiv_imm: assert property (np & (req_i.form == DDS_F_UDIV_IMM) |=>
    rsp_o.bytes == 4'h3 + 4'($past(req_i.size)) && rsp_o.cycles == ($past(req_i.size) ? 6'h17 : 6'h12))
    else $error("unsigned immediate counts wrong");
  a_xdiv_imm: assert property (np & (req_i.form == DDS_F_XDIV_IMM) |=>
    rsp_o.bytes == 4'h3 + 4'($past(req_i.size)) && rsp_o.cycles == ($past(req_i.size) ? 6'h18 : 6'h12))
    else $error("extended immediate counts wrong");
  a_dsb_reg_reg: assert property (np & (req_i.form == DDS_F_DSB_IMM) & req_i.dsb_gen &
    req_i.src[4] & req_i.dst[4] |=> rsp_o.cycles == 6'h02)
    else $error("decimal register cycles wrong");
  a_sdiv_word: assert property (np & (req_i.form == DDS_F_SDIV) & req_i.src[4] |=>
    rsp_o.bytes == ($past(req_i.size) ? 4'h8 : 4'h2))
    else $error("signed word bytes wrong");
endmodule
bind dds_decoder dds_props u_props (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rsp_o(rsp_o));

// *** dds_fetch_model.sv ***
// fetch-side model presenting operand requests to the decoder
// assumes: bench hands the next request before each falling edge
`timescale 1ns/100ps
module dds_fetch_model
(
  input wire logic clk_i,
  input wire dds_pkg::dds_req_t nxt_i,
  output dds_pkg::dds_req_t req_o
);
  import dds_pkg::*;
  initial req_o = '0;
  // ==========================================================
  // launch on falling edge; idle fields are inverted so stale values never pass
  always @(negedge clk_i)
  begin
    if (nxt_i.valid)
      req_o <= nxt_i;
    else
      req_o <= {1'b0, ~nxt_i[$bits(dds_req_t)-2:0]};
  end
endmodule

// *** dds_pkg.sv ***
// package for the divide / decimal-subtract operand decoder
// assumes: used inside the core, one clock, synchronous reset
package dds_pkg;

  // ==========================================================
  // operand field encodings
  localparam logic [4:0] DDS_OP_IND_A0 = 5'h00;
  localparam logic [4:0] DDS_OP_IND_A1 = 5'h01;
  localparam logic [4:0] DDS_OP_AR_A0 = 5'h02;
  localparam logic [4:0] DDS_OP_AR_A1 = 5'h03;
  localparam logic [4:0] DDS_OP_D8_A0 = 5'h04;
  localparam logic [4:0] DDS_OP_D8_A1 = 5'h05;
  localparam logic [4:0] DDS_OP_D8_SB = 5'h06;
  localparam logic [4:0] DDS_OP_D8_FB = 5'h07;
  localparam logic [4:0] DDS_OP_D16_A0 = 5'h08;
  localparam logic [4:0] DDS_OP_D16_A1 = 5'h09;
  localparam logic [4:0] DDS_OP_D16_SB = 5'h0a;
  localparam logic [4:0] DDS_OP_D16_FB = 5'h0b;
  localparam logic [4:0] DDS_OP_D24_A0 = 5'h0c;
  localparam logic [4:0] DDS_OP_D24_A1 = 5'h0d;
  localparam logic [4:0] DDS_OP_ABS24 = 5'h0e;
  localparam logic [4:0] DDS_OP_ABS16 = 5'h0f;
  localparam logic [4:0] DDS_OP_REG2 = 5'h10;
  localparam logic [4:0] DDS_OP_REG3 = 5'h11;
  localparam logic [4:0] DDS_OP_REG0 = 5'h12;
  localparam logic [4:0] DDS_OP_REG1 = 5'h13;
  localparam logic [4:0] DDS_OP_LOW_PAIR = 5'h12;
  localparam logic [4:0] DDS_OP_HIGH_PAIR = 5'h13;

  // ==========================================================
  // prefix bytes and size bit
  localparam logic [7:0] DDS_PFX_FIRST = 8'h09;
  localparam logic [7:0] DDS_PFX_BOTH = 8'h49;
  localparam logic DDS_SIZE_BYTE = 1'b0;
  localparam logic DDS_SIZE_WORD = 1'b1;

  // ==========================================================
  // byte and cycle figures
  localparam logic [3:0] DDS_LEN_SIZED = 4'h2;
  localparam logic [3:0] DDS_LEN_LONG = 4'h3;
  localparam logic [3:0] DDS_LEN_IMM = 4'h3;
  localparam logic [3:0] DDS_LEN_DSB_IMM = 4'h4;
  localparam logic [3:0] DDS_LEN_DSB_GEN = 4'h3;
  localparam logic [3:0] DDS_LEN_IND_ADD = 4'h1;
  localparam logic [3:0] DDS_LEN_WORD_ADD = 4'h1;
  localparam logic [3:0] DDS_LEN_SDIV_WORD_ADD = 4'h6;
  localparam logic [5:0] DDS_CYC_DIV_REG = 6'h12;
  localparam logic [5:0] DDS_CYC_DIV_MEM = 6'h14;
  localparam logic [5:0] DDS_CYC_LONG_REG = 6'h28;
  localparam logic [5:0] DDS_CYC_LONG_MEM = 6'h2a;
  localparam logic [5:0] DDS_CYC_IND_ADD = 6'h03;
  localparam logic [5:0] DDS_CYC_UNSIGNED_DIVIDE_WORD = 6'h05;
  localparam logic [5:0] DDS_CYC_EXTENDED_SIGNED_DIVIDE_WORD = 6'h06;
  localparam logic [5:0] DDS_CYC_DSB_RR = 6'h02;
  localparam logic [5:0] DDS_CYC_DSB_ONE = 6'h04;
  localparam logic [5:0] DDS_CYC_DSB_TWO = 6'h05;

  // ==========================================================
  // instruction forms, one-hot
  typedef enum logic [8:0] {
    DDS_F_SDIV = 9'h001,
    DDS_F_SDIV_L = 9'h002,
    DDS_F_UDIV_IMM = 9'h004,
    DDS_F_UDIV = 9'h008,
    DDS_F_UDIV_L = 9'h010,
    DDS_F_XDIV_IMM = 9'h020,
    DDS_F_XDIV = 9'h040,
    DDS_F_XDIV_L = 9'h080,
    DDS_F_DSB_IMM = 9'h100
  } dds_form_t;

  // request from fetch
  typedef struct packed {
    logic valid;
    dds_form_t form;
    logic dsb_gen;
    logic size;
    logic [4:0] src;
    logic [4:0] dst;
    logic pfx_valid;
    logic [7:0] pfx;
  } dds_req_t;

  // decoded result
  typedef struct packed {
    logic valid;
    logic illegal;
    logic word;
    logic src_ind;
    logic dst_ind;
    logic src_mem;
    logic dst_mem;
    logic long_pair_hi;
    logic [3:0] bytes;
    logic [5:0] cycles;
  } dds_rsp_t;

endpackage

// *** tb_top.sv ***
// self-checking bench for the operand decoder
// assumes: dds_pkg, decoder, checker and fetch model compiled first
`timescale 1ns/100ps
module tb_top;
  import dds_pkg::*;
`define CHK(g, x) \
  begin \
    cmp_count++; \
    if ((g) !== (x)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: decode field", $time); \
    end \
  end
  logic clk;
  logic rst;
  logic [31:0] seed;
  dds_req_t nxt;
  dds_req_t req;
  dds_rsp_t rsp;
  dds_req_t q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  // awkward cases: walk, bad long pair, both-indirect abs24, signed word dsp24
  dds_req_t dir [4] = '{'{1'b1, DDS_F_UDIV, 1'b0, 1'b1, 5'h00, 5'h00, 1'b0, 8'h00},
    '{1'b1, DDS_F_UDIV_L, 1'b0, 1'b0, 5'h10, 5'h00, 1'b0, 8'h00},
    '{1'b1, DDS_F_DSB_IMM, 1'b1, 1'b1, 5'h0e, 5'h0e, 1'b1, 8'h49},
    '{1'b1, DDS_F_SDIV, 1'b0, 1'b1, 5'h0c, 5'h00, 1'b1, 8'h09}};
  dds_fetch_model fetch (.clk_i(clk), .nxt_i(nxt), .req_o(req));
  dds_decoder uut (.clk_i(clk), .rst_i(rst), .req_i(req), .rsp_o(rsp));
  // ==========================================================
  // expectation helpers
  function automatic logic [3:0] dsp_f(logic [4:0] c);
    if (c[4] || c < 5'h04)
      return 4'h0;
    if (c < 5'h08)
      return 4'h1;
    if (c < 5'h0c || c == 5'h0f)
      return 4'h2;
    return 4'h3;
  endfunction
  function automatic dds_rsp_t exp_f(dds_req_t r);
    dds_rsp_t e;
    logic lng, immediate_operand, p9, p49, sm, dm;
    e = '0;
    e.valid = r.valid;
    lng = r.form inside {DDS_F_SDIV_L, DDS_F_UDIV_L, DDS_F_XDIV_L};
    immediate_operand = r.form inside {DDS_F_UDIV_IMM, DDS_F_XDIV_IMM};
    p9 = r.pfx_valid & (r.pfx == DDS_PFX_FIRST);
    p49 = r.pfx_valid & (r.pfx == DDS_PFX_BOTH);
    sm = ~r.src[4] & (r.src[4:1] != 4'h1);
    dm = ~r.dst[4] & (r.dst[4:1] != 4'h1);
    e.word = r.size & ~lng;
    e.illegal = (r.pfx_valid & ~p9 & ~p49) | ((lng | immediate_operand) & r.pfx_valid) | (lng & (r.src[4:1] == 4'h8))
      | (p49 & ~((r.form == DDS_F_DSB_IMM) & r.dsb_gen));
    if (lng | immediate_operand)
    begin
      e.src_mem = sm & lng;
      e.long_pair_hi = r.src == DDS_OP_HIGH_PAIR;
      e.bytes = lng ? 4'h3 + dsp_f(r.src) : 4'h3 + 4'(r.size);
      e.cycles = lng ? (sm ? 6'h2a : 6'h28) : 6'h12 + (r.size ? (r.form == DDS_F_UDIV_IMM ? 6'h5 : 6'h6) : 6'h0);
    end
    else if (r.form != DDS_F_DSB_IMM)
    begin
      e.src_ind = p9;
      e.src_mem = sm;
      e.bytes = 4'h2 + dsp_f(r.src) + 4'(p9) + ((r.size && r.form == DDS_F_SDIV) ? 4'h6 : 4'h0);
      e.cycles = (sm ? 6'h14 : 6'h12) + (p9 ? 6'h3 : 6'h0) + (r.size ? (r.form == DDS_F_UDIV ? 6'h5 :
        r.form == DDS_F_XDIV ? 6'h6 : 6'h0) : 6'h0);
    end
    else
    begin
      sm = sm & r.dsb_gen;
      e.dst_mem = dm;
      e.src_ind = p49;
      e.dst_ind = p9 | p49;
      e.bytes = (r.dsb_gen ? 4'h3 + dsp_f(r.src) : 4'h4 + 4'(r.size)) + dsp_f(r.dst) + 4'(p9 | p49);
      e.cycles = ((sm & dm) ? 6'h5 : (sm | dm) ? 6'h4 : 6'h2) + (p49 ? 6'h6 : p9 ? 6'h3 : 6'h0);
    end
    return e;
  endfunction
  task automatic chk_t(dds_req_t r);
    dds_rsp_t e;
    e = exp_f(r);
    `CHK(rsp.valid, e.valid)
    if (e.valid)
    begin
      `CHK(rsp.illegal, e.illegal)
      if (!e.illegal)
      begin
        `CHK(rsp.word, e.word)
        `CHK(rsp.src_ind, e.src_ind)
        `CHK(rsp.dst_ind, e.dst_ind)
        `CHK(rsp.bytes, e.bytes)
        `CHK(rsp.cycles, e.cycles)
        `CHK(rsp.dst_mem, e.dst_mem)
        if (r.form != DDS_F_DSB_IMM)
          `CHK(rsp.src_mem, e.src_mem)
        if (r.form inside {DDS_F_SDIV_L, DDS_F_UDIV_L, DDS_F_XDIV_L})
          `CHK(rsp.long_pair_hi, e.long_pair_hi)
      end
    end
  endtask
  function automatic logic [31:0] xs_f(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic dds_req_t rnd_f(logic [31:0] x);
    dds_req_t r;
    r.valid = x[0] | x[1];
    r.form = dds_form_t'(9'h001 << (x[7:4] % 9));
    r.dsb_gen = x[8];
    r.size = x[9];
    r.src = 5'(x[14:10] % 20);
    r.dst = 5'(x[19:15] % 20);
    r.pfx_valid = x[20] & x[21];
    r.pfx = x[23] ? (x[22] ? DDS_PFX_BOTH : DDS_PFX_FIRST) : x[31:24];
    return r;
  endfunction
  // back-to-back issue; result checked two falling edges later
  task automatic step(dds_req_t r);
    @(negedge clk);
    if (q.size() == 2)
      chk_t(q.pop_front());
    nxt <= r;
    q.push_back(r);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // clock, hang guard, main sequence
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    rst = 1'b1;
    nxt = '0;
    seed = 32'hea65;
    repeat (16) @(negedge clk);
    rst <= 1'b0;
    foreach (dir[i]) step(dir[i]);
    repeat (1200)
    begin
      seed = xs_f(seed);
      step(rnd_f(seed));
    end
    step('0);
    step('0);
    // reset in mid-run wins over a live request
    @(negedge clk);
    rst <= 1'b1;
    nxt <= dir[0];
    repeat (2) @(negedge clk);
    `CHK(rsp, '0)
    nxt <= '0;
    @(negedge clk);
    rst <= 1'b0;
    q.delete();
    foreach (dir[i]) step(dir[i]);
    repeat (2) step('0);
    conclude();
  end
endmodule
